// ==== rtl/adc_readout_pkg.sv ====
package adc_readout_pkg;
  // ==================================================
  // conversion and strobe timing
  localparam int WORD_W     = 18;
  localparam int OSR        = 32;
  localparam int HALF_PER   = 16;
  localparam int SETTLE_CYC = 46;
  localparam int LVL_W      = 3;
  localparam int ACC_W      = WORD_W + 5;
  localparam int CLK_PER_NS = 20;
  localparam logic [4:0] PH_LAST  = 5'(OSR - 1);
  localparam logic [4:0] PH_RISE  = 5'(HALF_PER - 1);
  localparam logic [5:0] SETTLE_N = 6'(SETTLE_CYC);
  // ==================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_WORD   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SETTLE = 8'h10;
  localparam logic [2:0] MASK_RST    = 3'h0;
  localparam logic       CTRL_RST    = 1'b0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==================================================
  // types
  typedef struct packed {
    logic settled;
    logic ovr;
    logic word;
  } irq_s;
  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic              oe;
  } sample_bus_s;
  typedef enum logic {MODE_DIRECT, MODE_BUFFERED} mode_e;
endpackage

// ==== rtl/adc_parallel_readout.sv ====
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module adc_parallel_readout (
  input  wire logic                               ref_clk_i, // 50 MHz
  input  wire logic                               rst_i, // async, high
  input  wire logic                               awvalid_i, // axi write addr
  output logic                                    awready_o, // axi
  input  wire logic [adc_readout_pkg::ADDR_W-1:0] awaddr_i, // byte
  input  wire logic                               wvalid_i, // axi write data
  output logic                                    wready_o, // axi
  input  wire logic [31:0]                        wdata_i, // axi
  input  wire logic [3:0]                         wstrb_i, // axi lanes
  output logic                                    bvalid_o, // axi response
  input  wire logic                               bready_i, // axi
  output logic [1:0]                              bresp_o, // axi
  input  wire logic                               arvalid_i, // axi read addr
  output logic                                    arready_o, // axi
  input  wire logic [adc_readout_pkg::ADDR_W-1:0] araddr_i, // byte
  output logic                                    rvalid_o, // axi read data
  input  wire logic                               rready_i, // axi
  output logic [31:0]                             rdata_o, // axi
  output logic [1:0]                              rresp_o, // axi
  output logic                                    irq_o, // level, high
  input  wire logic                               reset_n_i, // filter reset
  input  wire logic                               cs_n_i, // chip select
  input  wire logic                               rd_n_i, // read enable
  input  wire logic                               powerdown_n_i, // power-down
  input  wire logic                               int_vref_on_n_i, // ref sel
  input  wire logic [2:0]                         buffer_depth_sel_i, // level
  input  wire logic [17:0]                        mod_word_i, // modulator
  input  wire logic                               over_range_i, // overload
  output adc_readout_pkg::sample_bus_s            sample_bus_o, // bus
  output logic                                    sample_ready_n_o, // strobe
  output logic                                    over_range_flag_o, // ovr
  output logic                                    vref_internal_o // ref used
);
  import adc_readout_pkg::*;

  // ==================================================
  // declarations
  logic                    run;
  mode_e                   mode;
  logic [LVL_W-1:0]        level;
  logic [4:0]              osr_ph;
  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] acc_sum;
  logic [WORD_W-1:0]       fresh;
  logic [WORD_W-1:0]       word;
  logic                    word_stb;
  logic [WORD_W-1:0]       mem [16];
  logic                    wbank;
  logic [LVL_W-1:0]        widx;
  logic [LVL_W-1:0]        ridx;
  logic                    burst_done;
  logic                    primed;
  logic                    rd_sel;
  logic                    rd_prev;
  logic                    rd_fall;
  logic [WORD_W-1:0]       sample_q;
  logic                    ready_n;
  logic                    next_ready_n;
  logic                    fall_evt;
  logic [5:0]              settle_cnt;
  logic                    settled;
  logic                    ovr_q;
  logic                    vref_q;
  irq_s                    ev;
  irq_s                    status;
  irq_s                    next_status;
  logic [2:0]              mask;
  logic                    ctrl_hold;
  logic                    aw_full;
  logic [ADDR_W-1:0]       aw_addr;
  logic                    w_full;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    do_wr;
  logic                    rd_take;
  logic                    rd_clr;
  logic [31:0]             rd_word;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == OFS_STATUS || a == OFS_MASK || a == OFS_WORD ||
           a == OFS_CTRL || a == OFS_SETTLE;
  endfunction

  // ==================================================
  // mode and decimation
  // software hold acts like the pin: a driver can restart settling
  assign run   = reset_n_i & powerdown_n_i & ~ctrl_hold;
  assign level = buffer_depth_sel_i;
  assign mode  = (level == '0) ? MODE_DIRECT : MODE_BUFFERED;
  assign acc_sum = acc + {{(ACC_W-WORD_W){mod_word_i[WORD_W-1]}},
                          mod_word_i};
  assign fresh    = acc_sum[ACC_W-1 -: WORD_W];
  assign word_stb = run & (osr_ph == PH_LAST);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      osr_ph <= '0;
      acc    <= '0;
      word   <= '0;
    end else if (!run) begin
      osr_ph <= '0;
      acc    <= '0;
      word   <= '0;
    end else begin
      osr_ph <= osr_ph + 5'h01;
      acc    <= word_stb ? '0 : acc_sum;
      if (word_stb) word <= fresh;
    end
  end

  // ==================================================
  // output buffer: two banks keep a burst apart from the next one
  assign burst_done = word_stb & (mode == MODE_BUFFERED) &
                      (widx == level - 3'h1);
  always_ff @(posedge ref_clk_i) begin
    if (word_stb) mem[{wbank, widx}] <= fresh;
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      widx   <= '0;
      wbank  <= 1'b0;
      primed <= 1'b0;
    end else if (!run) begin
      widx   <= '0;
      wbank  <= 1'b0;
      primed <= 1'b0;
    end else begin
      if (mode == MODE_DIRECT) widx <= '0;
      else if (word_stb) widx <= burst_done ? '0 : widx + 3'h1;
      if (burst_done) wbank <= ~wbank;
      if (mode == MODE_DIRECT ? word_stb : burst_done) primed <= 1'b1;
    end
  end

  // ==================================================
  // parallel read port
  assign rd_sel  = ~cs_n_i & ~rd_n_i;
  assign rd_fall = rd_sel & ~rd_prev;
  assign sample_bus_o.data = sample_q;
  assign sample_bus_o.oe   = rd_sel;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_prev  <= 1'b0;
      ridx     <= '0;
      sample_q <= '0;
    end else begin
      rd_prev <= rd_sel;
      if (!run) begin
        ridx     <= '0;
        sample_q <= '0;
      end else if (mode == MODE_DIRECT) begin
        if (word_stb) sample_q <= fresh;
      end else if (burst_done) begin
        ridx <= '0;
      end else if (rd_fall) begin
        sample_q <= mem[{~wbank, ridx}];
        ridx     <= ridx + 3'h1;
      end
    end
  end

  // ==================================================
  // ready strobe and settling
  // held high until the first word (first burst when buffered): no fall before real data
  always_comb begin
    if (!run) next_ready_n = 1'b1;
    else if (mode == MODE_DIRECT)
      next_ready_n = ~(primed | word_stb) |
        (osr_ph >= PH_RISE && osr_ph != PH_LAST);
    else next_ready_n = burst_done | ~primed;
  end
  assign fall_evt = ready_n & ~next_ready_n;
  assign settled  = settle_cnt == SETTLE_N;
  assign sample_ready_n_o = ready_n;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_n    <= 1'b1;
      settle_cnt <= '0;
      ovr_q      <= 1'b0;
      vref_q     <= 1'b0;
    end else begin
      ready_n <= next_ready_n;
      if (!run) settle_cnt <= '0;
      else if (fall_evt && !settled)
        settle_cnt <= settle_cnt + 6'h01;
      ovr_q  <= over_range_i & powerdown_n_i;
      vref_q <= ~int_vref_on_n_i & powerdown_n_i;
    end
  end
  assign over_range_flag_o = ovr_q;
  assign vref_internal_o   = vref_q;

  // ==================================================
  // register slave
  assign awready_o = ~aw_full & ~bvalid_o;
  assign wready_o  = ~w_full & ~bvalid_o;
  assign arready_o = ~rvalid_o;
  assign do_wr     = aw_full & w_full;
  assign rd_take   = arvalid_i & ~rvalid_o;
  assign rd_clr    = rd_take & (araddr_i == OFS_STATUS);
  assign ev.word    = fall_evt;
  assign ev.ovr     = over_range_i & powerdown_n_i & ~ovr_q;
  assign ev.settled = fall_evt & (settle_cnt == SETTLE_N - 6'h01);
  // a new event in the clearing cycle survives the read
  assign next_status = (status & ~{3{rd_clr}}) | ev;
  assign irq_o = |(status & mask);
  assign rd_word =
    (araddr_i == OFS_STATUS) ? 32'(status) :
    (araddr_i == OFS_MASK)   ? 32'(mask) :
    (araddr_i == OFS_WORD)   ? 32'(word) :
    (araddr_i == OFS_CTRL)   ? 32'(ctrl_hold) :
    (araddr_i == OFS_SETTLE) ? 32'({settled, 2'h0, settle_cnt}) :
    32'h0000_0000;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
      w_full  <= 1'b0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_full <= 1'b1;
        aw_addr <= awaddr_i;
      end else if (do_wr) aw_full <= 1'b0;
      if (wvalid_i && wready_o) begin
        w_full <= 1'b1;
        w_data <= wdata_i;
        w_strb <= wstrb_i;
      end else if (do_wr) w_full <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_o  <= 1'b0;
      bresp_o   <= RESP_OKAY;
      mask      <= MASK_RST;
      ctrl_hold <= CTRL_RST;
    end else begin
      if (do_wr) begin
        bvalid_o <= 1'b1;
        bresp_o  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr == OFS_MASK && w_strb[0]) mask <= w_data[2:0];
        if (aw_addr == OFS_CTRL && w_strb[0]) ctrl_hold <= w_data[0];
      end else if (bready_i) bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= '0;
      rresp_o  <= RESP_OKAY;
      status   <= '0;
    end else begin
      status <= next_status;
      if (rd_take) begin
        rvalid_o <= 1'b1;
        rdata_o  <= rd_word;
        rresp_o  <= mapped(araddr_i) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready_i) rvalid_o <= 1'b0;
    end
  end

  // ==================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_low16;
    !sample_ready_n_o [*8] ##1 !sample_ready_n_o [*8];
  endsequence
  sequence s_high16;
    sample_ready_n_o [*8] ##1 sample_ready_n_o [*8];
  endsequence

  a_drive_sel: assert property (
    !cs_n_i && !rd_n_i |-> sample_bus_o.oe)
    else $error("bus not driven while selected");
  a_release_hiz: assert property (
    cs_n_i || rd_n_i |-> !sample_bus_o.oe)
    else $error("bus driven while released");
  a_reset_force: assert property (
    !reset_n_i |=> sample_ready_n_o && sample_bus_o.data == '0)
    else $error("reset pin did not force outputs");
  a_direct_strobe: assert property (
    disable iff (rst_i || !run || mode != MODE_DIRECT)
    $fell(sample_ready_n_o) |-> s_low16 ##1 s_high16
      ##1 !sample_ready_n_o)
    else $error("direct strobe not 16 low 16 high");
  a_buf_pulse: assert property (
    disable iff (rst_i || !run || mode != MODE_BUFFERED)
    $rose(sample_ready_n_o) && primed |=> !sample_ready_n_o)
    else $error("buffered pulse not one cycle");
  a_decim_rate: assert property (
    disable iff (rst_i || !run)
    word_stb |=> !word_stb [*8] ##24 word_stb)
    else $error("word rate not 32 clocks");
  a_word_load: assert property (
    run && mode == MODE_DIRECT && word_stb
      |=> sample_bus_o.data == $past(fresh))
    else $error("new word not presented");
  a_settle_mark: assert property (
    $rose(settled) |-> $past(fall_evt) &&
      $past(settle_cnt) == SETTLE_N - 6'h01)
    else $error("settled flag at wrong count");
  a_ovr_follow: assert property (
    over_range_i && powerdown_n_i |=> over_range_flag_o)
    else $error("over-range not reported");
  a_pd_quiet: assert property (
    !powerdown_n_i |=> sample_ready_n_o && !over_range_flag_o)
    else $error("activity during power-down");
  a_vref_sel: assert property (
    !int_vref_on_n_i && powerdown_n_i |=> vref_internal_o)
    else $error("internal reference not selected");
endmodule

// ==== verif/host_reader.sv ====
`timescale 1ns/100ps
// ==================================================
// host side of the parallel sample bus
module host_reader (
  input  wire adc_readout_pkg::sample_bus_s bus_i,  // sample bus
  input  wire logic                         clk_i,  // sample clock
  output logic                              cs_n_o, // chip select
  output logic                              rd_n_o  // read strobe
);
  import adc_readout_pkg::*;
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
  end
  // caller starts just after an edge; the word is taken only while driven
  task automatic read_word(output logic [17:0] d, output logic oe);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    @(posedge clk_i);
    @(posedge clk_i);
    oe = bus_i.oe;
    d = bus_i.oe ? bus_i.data : ~bus_i.data;
    rd_n_o <= 1'b1;
    cs_n_o <= 1'b1;
    @(posedge clk_i);
  endtask
endmodule

// ==== verif/tb_adc_parallel_readout.sv ====
`timescale 1ns/100ps
module tb_adc_parallel_readout;
  import adc_readout_pkg::*;
  localparam logic [17:0] W = 18'h2a5c3;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, irq;
  logic        arvalid, arready, rvalid, rready, ready_n, oflag, vint;
  logic        pin_rst_n, cs_n, rd_n, pd_n, vref_n, ovr;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [2:0]  sel;
  logic [17:0] mword;
  sample_bus_s sbus;
  int          mismatches = 0;
  int          tests_run = 0;
  always #10 clk = ~clk;
  adc_parallel_readout dut (
    .ref_clk_i(clk), .rst_i(rst), .awvalid_i(awvalid),
    .awready_o(awready), .awaddr_i(awaddr), .wvalid_i(wvalid),
    .wready_o(wready), .wdata_i(wdata), .wstrb_i(4'hf),
    .bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp),
    .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr),
    .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata),
    .rresp_o(rresp), .irq_o(irq), .reset_n_i(pin_rst_n),
    .cs_n_i(cs_n), .rd_n_i(rd_n), .powerdown_n_i(pd_n),
    .int_vref_on_n_i(vref_n), .buffer_depth_sel_i(sel),
    .mod_word_i(mword), .over_range_i(ovr), .sample_bus_o(sbus),
    .sample_ready_n_o(ready_n), .over_range_flag_o(oflag),
    .vref_internal_o(vint));
  host_reader host (.bus_i(sbus), .clk_i(clk), .cs_n_o(cs_n),
    .rd_n_o(rd_n));
  // ==================================================
  // shared helpers
  task automatic complete_run;
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic give_up(input string nm);
    check(nm, 32'h1, 32'h0);
    complete_run;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 50) give_up("write timeout");
    check("bresp", {30'h0, RESP_OKAY}, {30'h0, bresp});
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n == 50) give_up("read timeout");
  endtask
  task automatic wait_fall;
    logic p;
    p = ready_n;
    repeat (600) begin
      @(posedge clk);
      #1;
      if (p === 1'b1 && ready_n === 1'b0) return;
      p = ready_n;
    end
    give_up("strobe timeout");
  endtask
  // edges until the strobe leaves level lv, at most 200
  task automatic count_level(input logic lv, output int n);
    n = 0;
    while (n < 200) begin
      @(posedge clk);
      #1;
      n++;
      if (ready_n !== lv) break;
    end
  endtask
  task automatic restart;
    @(posedge clk);
    pin_rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    pin_rst_n <= 1'b1;
  endtask
  // ==================================================
  // scenarios
  task automatic t_direct;
    int n;
    logic [17:0] d;
    logic o;
    logic [31:0] q;
    logic [1:0] r;
    restart;
    wait_fall;
    check("word", {14'h0, W}, {14'h0, sbus.data});
    count_level(1'b0, n);
    check("low span", 32'd16, n);
    count_level(1'b1, n);
    check("high span", 32'd16, n);
    host.read_word(d, o);
    check("bus driven", 32'h1, {31'h0, o});
    check("bus word", {14'h0, W}, {14'h0, d});
    #1;
    check("bus released", 32'h0, {31'h0, sbus.oe});
    axi_rd(OFS_WORD, q, r);
    check("word reg", {14'h0, W}, q);
  endtask
  task automatic t_pin_reset;
    @(posedge clk);
    pin_rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("rst strobe", 32'h1, {31'h0, ready_n});
    check("rst word", 32'h0, {14'h0, sbus.data});
    @(posedge clk);
    pin_rst_n <= 1'b1;
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(OFS_MASK, 32'h2);
    axi_rd(OFS_MASK, d, r);
    check("mask", 32'h2, d);
    axi_rd(8'h20, d, r);
    check("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    check("unmapped data", 32'h0, d);
    axi_rd(OFS_STATUS, d, r);
    @(posedge clk);
    ovr <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("range flag", 32'h1, {31'h0, oflag});
    check("irq set", 32'h1, {31'h0, irq});
    axi_rd(OFS_STATUS, d, r);
    check("status ovr", 32'h1, {31'h0, d[1]});
    axi_rd(OFS_STATUS, d, r);
    check("status clr", 32'h0, {31'h0, d[1]});
    check("irq clr", 32'h0, {31'h0, irq});
    axi_wr(OFS_MASK, 32'h0);
    ovr <= 1'b0;
    @(posedge clk);
    ovr <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("irq masked", 32'h0, {31'h0, irq});
    @(posedge clk);
    ovr <= 1'b0;
  endtask
  task automatic t_hold;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(OFS_CTRL, 32'h1);
    axi_rd(OFS_CTRL, d, r);
    check("hold", 32'h1, d);
    axi_rd(OFS_WORD, d, r);
    check("hold word", 32'h0, d);
    axi_rd(OFS_SETTLE, d, r);
    check("hold settle", 32'h0, d);
    check("hold strobe", 32'h1, {31'h0, ready_n});
    axi_wr(OFS_CTRL, 32'h0);
  endtask
  task automatic t_settle;
    logic [31:0] d;
    logic [1:0] r;
    restart;
    repeat (45) wait_fall;
    axi_rd(OFS_SETTLE, d, r);
    check("settle 45", 32'h2d, d);
    wait_fall;
    axi_rd(OFS_SETTLE, d, r);
    check("settle 46", 32'h12e, d);
    axi_rd(OFS_STATUS, d, r);
    check("status settled", 32'h1, {31'h0, d[2]});
  endtask
  task automatic t_power;
    int n;
    @(posedge clk);
    vref_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("int ref", 32'h1, {31'h0, vint});
    @(posedge clk);
    pd_n <= 1'b0;
    ovr <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    count_level(1'b1, n);
    check("pd strobe", 32'd200, n);
    check("pd flag", 32'h0, {31'h0, oflag});
    check("pd ref", 32'h0, {31'h0, vint});
    @(posedge clk);
    pd_n <= 1'b1;
    ovr <= 1'b0;
    vref_n <= 1'b1;
  endtask
  task automatic t_buffered;
    int n;
    logic [17:0] d;
    logic o;
    @(posedge clk);
    sel <= 3'h2;
    restart;
    wait_fall;
    count_level(1'b0, n);
    check("buf low", 32'd63, n);
    count_level(1'b1, n);
    check("buf pulse", 32'd1, n);
    repeat (2) begin
      host.read_word(d, o);
      check("burst word", {14'h0, W}, {14'h0, d});
    end
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, ovr} = 6'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    {pin_rst_n, pd_n, vref_n} = 3'h7;
    sel = 3'h0;
    mword = W;
    repeat (10) @(posedge clk);
    check("init strobe", 32'h1, {31'h0, ready_n});
    check("init word", 32'h0, {14'h0, sbus.data});
    rst <= 1'b0;
    t_direct;
    t_pin_reset;
    t_regs;
    t_hold;
    t_settle;
    t_power;
    t_buffered;
    complete_run;
  end
endmodule
